//--- hdl/bscan_pkg.sv
package bscan_pkg;
   // Instruction register
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_IDCODE = 4'h1;
   localparam logic [3:0] OP_SAMPLE = 4'h2;
   localparam logic [3:0] OP_CHIP_RESET = 4'hC;
   localparam logic [3:0] OP_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // Identification register layout
   localparam int ID_WIDTH = 32;
   localparam int ID_VER_W = 4;
   localparam int ID_PART_W = 16;
   localparam int ID_MFR_W = 11;
   // Boundary chain cells of one port pin
   localparam int CELLS_PER_PIN = 3;
   localparam int CELL_PU = 0;
   localparam int CELL_OC = 1;
   localparam int CELL_DATA = 2;
   // Register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_SYSCTRL = 8'h00;
   localparam logic [7:0] OFF_CAUSE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam int TPD_BIT = 7;
   localparam int CAUSE_FLAG_BIT = 4;
   localparam logic [6:0] SYSCTRL_LOW_RESET = 7'h00;
   localparam logic TPD_RESET = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing, in clk_sys cycles
   localparam int TIMED_WINDOW = 4;
   localparam int RESET_TIMEOUT_DEFAULT = 64;

   typedef enum {DR_BOUNDARY, DR_ID, DR_RESET, DR_BYPASS} dr_sel_t;
endpackage : bscan_pkg

//--- hdl/boundary_scan_test_access.sv
// What this block does
// RL1 - Instruction register is four bits wide
// RL2 - All scan registers shift LSB first
// RL3 - Code 0x0 selects boundary chain
// RL4 - EXTEST drives latched outputs onto pins immediately
// RL5 - EXTEST capture samples, shift shifts, update applies
// RL6 - Code 0x1 selects ID register, power-up default
// RL7 - ID holds version, part, manufacturer fields
// RL8 - Preload updates latches, pins stay system-driven
// RL9 - Code 0xC selects one-bit chip reset register
// RL10 - Chip held in reset while register is one
// RL11 - Bypass cell captures zero, shifts one bit
// RL12 - No high-Z code; reset tri-states pins
// RL13 - Disable bit off plus fuse enables port
// RL14 - Disable bit needs equal double write, four cycles
// RL15 - Software should disable an unconnected port
// RL16 - Cause flag set by test reset, write-zero clears
// RL17 - Pin has pull-up cell plus two-stage cell
// RL18 - System values feed cells when no scan
// RL19 - Alternate functions sit outside the scan cells
// RL20 - Two-wire pins carry one extra enable cell
// RL21 - Tester never enables driver and two-wire together
// RL22 - ID fields are 4, 16 and 11 bits
// RL23 - Reset lasts a time-out after release
// RL24 - Unassigned codes select the bypass cell
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module boundary_scan_test_access import bscan_pkg::*; #(
   parameter int PIN_COUNT = 8,
   parameter int TW_COUNT = 2,
   // Identification values are arbitrary
   parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h1,
   parameter logic [ID_PART_W-1:0] ID_PART = 16'h5A3C,
   parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h2B5,
   parameter int RESET_TIMEOUT = RESET_TIMEOUT_DEFAULT
) (
   // System
   input wire logic clk_sys,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Test port pins and controller state
   input wire logic tck,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic tap_reset,
   input wire logic tap_capture_ir,
   input wire logic tap_shift_ir,
   input wire logic tap_update_ir,
   input wire logic tap_capture_dr,
   input wire logic tap_shift_dr,
   input wire logic tap_update_dr,
   input wire logic test_port_fuse,
   // Port pins
   input wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe,
   output logic [PIN_COUNT-1:0] pin_pullup_enable,
   output logic [TW_COUNT-1:0] twowire_buffer_enable,
   // System port logic
   input wire logic [PIN_COUNT-1:0] pin_port_bit,
   input wire logic [PIN_COUNT-1:0] pin_direction_bit,
   input wire logic global_pullup_disable,
   input wire logic [TW_COUNT-1:0] twowire_sys_enable,
   output logic [PIN_COUNT-1:0] pin_input_register,
   output logic chip_reset
);
   localparam int CHAIN = CELLS_PER_PIN * PIN_COUNT + TW_COUNT;
   localparam int AW = 10 + PIN_COUNT;
   localparam int TO_W = $clog2(RESET_TIMEOUT + 1);
   localparam logic [ID_WIDTH-1:0] ID_VALUE =
      {ID_VERSION, ID_PART, ID_MFR, 1'b1}; // see RL7 RL22

   function automatic dr_sel_t decode_dr(input logic [IR_WIDTH-1:0] op);
      dr_sel_t sel;
      sel = DR_BYPASS; // see RL24
      if (op == OP_EXTEST || op == OP_SAMPLE) sel = DR_BOUNDARY;
      if (op == OP_IDCODE) sel = DR_ID;
      if (op == OP_CHIP_RESET) sel = DR_RESET; // see RL9
      return sel;
   endfunction : decode_dr

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      return a == OFF_SYSCTRL || a == OFF_CAUSE || a == OFF_STATUS;
   endfunction : addr_mapped

   // Everything from the pins passes two flip-flops first
   logic [AW-1:0] async_vec;
   logic [AW-1:0] meta;
   logic [AW-1:0] sync;
   logic tck_s, tdi_s, tap_reset_s, cap_ir_s, sh_ir_s, upd_ir_s;
   logic cap_dr_s, sh_dr_s, upd_dr_s, fuse_s;
   logic [PIN_COUNT-1:0] pin_s;
   assign async_vec = {tck, tdi, tap_reset, tap_capture_ir, tap_shift_ir,
      tap_update_ir, tap_capture_dr, tap_shift_dr, tap_update_dr,
      test_port_fuse, pin_in};
   assign {tck_s, tdi_s, tap_reset_s, cap_ir_s, sh_ir_s, upd_ir_s,
      cap_dr_s, sh_dr_s, upd_dr_s, fuse_s, pin_s} = sync;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= async_vec;
         sync <= meta;
      end
   end

   logic tck_d;
   logic tck_rise, tck_fall, port_on, test_port_disable;
   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;
   assign port_on = fuse_s & ~test_port_disable; // see RL13

   always_ff @(posedge clk_sys) begin
      if (!rst_n) tck_d <= 1'b0;
      else tck_d <= tck_s;
   end

   // Instruction register
   logic [IR_WIDTH-1:0] instr;
   logic [IR_WIDTH-1:0] ir_shift;
   dr_sel_t dr_sel;
   assign dr_sel = decode_dr(instr); // see RL3

   always_ff @(posedge clk_sys) begin
      if (!rst_n || !port_on) begin
         instr <= OP_IDCODE; // see RL6
         ir_shift <= IR_CAPTURE;
      end else if (tck_rise) begin
         if (tap_reset_s) instr <= OP_IDCODE;
         else if (upd_ir_s) instr <= ir_shift; // see RL1
         if (cap_ir_s) ir_shift <= IR_CAPTURE;
         else if (sh_ir_s) ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]};
      end
   end

   // Capture sources and update latches of the boundary chain
   logic [CHAIN-1:0] cap_vec;
   logic [CHAIN-1:0] bs_shift;
   logic [CHAIN-1:0] bs_latch;
   logic [PIN_COUNT-1:0] sys_pullup, lat_pu, lat_oc, lat_od;
   logic [TW_COUNT-1:0] lat_tw;
   assign sys_pullup = ~{PIN_COUNT{global_pullup_disable}}
      & ~pin_direction_bit & pin_port_bit; // see RL18

   // Alternate pin functions attach outside these cells, so the data
   // stage always sees the real pin level
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      assign cap_vec[CELLS_PER_PIN*i+CELL_PU] = sys_pullup[i]; // see RL17
      assign cap_vec[CELLS_PER_PIN*i+CELL_OC] = pin_direction_bit[i];
      assign cap_vec[CELLS_PER_PIN*i+CELL_DATA] = pin_s[i]; // see RL19
      assign lat_pu[i] = bs_latch[CELLS_PER_PIN*i+CELL_PU];
      assign lat_oc[i] = bs_latch[CELLS_PER_PIN*i+CELL_OC];
      assign lat_od[i] = bs_latch[CELLS_PER_PIN*i+CELL_DATA];
   end
   for (genvar j = 0; j < TW_COUNT; j++) begin : g_tw
      assign cap_vec[CELLS_PER_PIN*PIN_COUNT+j] = twowire_sys_enable[j];
      assign lat_tw[j] = bs_latch[CELLS_PER_PIN*PIN_COUNT+j]; // see RL20
   end

   // Data registers
   logic [ID_WIDTH-1:0] id_shift;
   logic bypass_cell;
   logic rst_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         id_shift <= '0;
         bypass_cell <= 1'b0;
         rst_reg <= 1'b0;
         bs_shift <= '0;
         bs_latch <= '0;
      end else if (!port_on) begin
         rst_reg <= 1'b0;
      end else if (tck_rise) begin
         if (cap_dr_s) begin
            unique case (dr_sel)
               DR_BOUNDARY: bs_shift <= cap_vec; // see RL5
               DR_ID: id_shift <= ID_VALUE;
               DR_BYPASS: bypass_cell <= 1'b0; // see RL11
               DR_RESET: ;
            endcase
         end else if (sh_dr_s) begin
            unique case (dr_sel)
               DR_BOUNDARY: bs_shift <= {tdi_s, bs_shift[CHAIN-1:1]};
               DR_ID: id_shift <= {tdi_s, id_shift[ID_WIDTH-1:1]}; // see RL2
               DR_BYPASS: bypass_cell <= tdi_s;
               DR_RESET: rst_reg <= tdi_s; // see RL9
            endcase
         end
         // Preload fills the latches; only EXTEST routes them out
         if (upd_dr_s && dr_sel == DR_BOUNDARY)
            bs_latch <= bs_shift; // see RL8
      end
   end

   // Data leaves on the falling test clock edge
   logic dr_lsb, next_tdo;
   assign dr_lsb = dr_sel == DR_BOUNDARY ? bs_shift[0] :
      dr_sel == DR_ID ? id_shift[0] :
      dr_sel == DR_RESET ? rst_reg : bypass_cell;
   assign next_tdo = sh_ir_s ? ir_shift[0] : dr_lsb;

   always_ff @(posedge clk_sys) begin
      if (!rst_n || !port_on) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo <= next_tdo;
         tdo_oe <= sh_ir_s | sh_dr_s;
      end
   end

   // Chip reset: register level, then the time-out
   logic [TO_W-1:0] to_cnt;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         to_cnt <= '0;
         chip_reset <= 1'b0;
      end else begin
         if (rst_reg) to_cnt <= TO_W'(RESET_TIMEOUT); // see RL23
         else if (to_cnt != '0) to_cnt <= to_cnt - 1'b1;
         chip_reset <= rst_reg | (to_cnt != '0); // see RL10
      end
   end

   // Pin drive
   logic extest;
   logic [PIN_COUNT-1:0] next_oe, next_out, next_pu;
   logic [TW_COUNT-1:0] next_tw;
   assign extest = instr == OP_EXTEST; // see RL4
   assign next_oe = extest ? lat_oc
      : pin_direction_bit & ~{PIN_COUNT{chip_reset}}; // see RL12
   assign next_out = extest ? lat_od : pin_port_bit;
   assign next_pu = extest ? lat_pu
      : sys_pullup & ~{PIN_COUNT{chip_reset}};
   assign next_tw = extest ? lat_tw
      : twowire_sys_enable & ~{TW_COUNT{chip_reset}};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_oe <= '0;
         pin_out <= '0;
         pin_pullup_enable <= '0;
         twowire_buffer_enable <= '0;
         pin_input_register <= '0;
      end else begin
         pin_oe <= next_oe;
         pin_out <= next_out;
         pin_pullup_enable <= next_pu;
         twowire_buffer_enable <= next_tw;
         pin_input_register <= pin_s;
      end
   end

   // AXI4-Lite write path
   logic [ADDR_W-1:0] aw_q;
   logic [31:0] w_q;
   logic strb_q, have_aw, have_w;
   logic wr_fire, wr_ctl, wr_cause, wd_tpd;
   assign wr_fire = have_aw & have_w & ~bvalid;
   assign wr_ctl = wr_fire & strb_q & (aw_q == OFF_SYSCTRL);
   assign wr_cause = wr_fire & strb_q & (aw_q == OFF_CAUSE);
   assign wd_tpd = w_q[TPD_BIT];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         strb_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_q <= awaddr;
            have_aw <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_q <= wdata;
            strb_q <= wstrb[0];
            have_w <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= addr_mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
            have_aw <= 1'b0;
            have_w <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // The disable bit only moves on a matching second write
   logic [6:0] sysctrl_low;
   logic tpd_arm, tpd_val;
   logic [2:0] tpd_cnt;
   logic cause_flag;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sysctrl_low <= SYSCTRL_LOW_RESET;
         test_port_disable <= TPD_RESET;
         tpd_arm <= 1'b0;
         tpd_val <= 1'b0;
         tpd_cnt <= '0;
      end else if (wr_ctl) begin
         sysctrl_low <= w_q[6:0];
         if (tpd_arm && tpd_val == wd_tpd) begin
            test_port_disable <= wd_tpd; // see RL14
            tpd_arm <= 1'b0;
         end else begin
            tpd_arm <= 1'b1;
            tpd_val <= wd_tpd;
            tpd_cnt <= '0;
         end
      end else if (tpd_arm) begin
         tpd_cnt <= tpd_cnt + 1'b1;
         if (tpd_cnt == 3'(TIMED_WINDOW - 1)) tpd_arm <= 1'b0;
      end
   end

   // A new set outranks a clearing write in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) cause_flag <= 1'b0;
      else if (rst_reg) cause_flag <= 1'b1; // see RL16
      else if (wr_cause && !w_q[CAUSE_FLAG_BIT]) cause_flag <= 1'b0;
   end

   // AXI4-Lite read path
   logic [31:0] rd_value;
   assign rd_value = araddr == OFF_SYSCTRL
      ? {24'h000000, test_port_disable, sysctrl_low}
      : araddr == OFF_CAUSE ? 32'(cause_flag) << CAUSE_FLAG_BIT
      : araddr == OFF_STATUS ? {26'h0, port_on, chip_reset, instr}
      : 32'h00000000;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_value;
         rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_step;
      tck_rise && port_on;
   endsequence
   sequence s_cap_bypass;
      s_step ##0 (cap_dr_s && dr_sel == DR_BYPASS);
   endsequence
   sequence s_cap_id;
      s_step ##0 (cap_dr_s && dr_sel == DR_ID);
   endsequence

   ir_load_a: assert property ( // see RL1
      s_step ##0 (upd_ir_s && !tap_reset_s) |=> instr == $past(ir_shift))
      else $error("instruction not loaded from shift stage");
   ir_lsb_first_a: assert property ( // see RL2
      s_step ##0 (sh_ir_s && !cap_ir_s) |=>
      ir_shift == {$past(tdi_s), $past(ir_shift[IR_WIDTH-1:1])})
      else $error("instruction shift not lsb first");
   extest_drive_a: assert property ( // see RL4
      extest |=> pin_oe == $past(lat_oc) && pin_out == $past(lat_od))
      else $error("extest latches not on pins");
   preload_iso_a: assert property ( // see RL8
      instr == OP_SAMPLE |=> pin_out == $past(pin_port_bit))
      else $error("preload disturbed pin output");
   idcode_cap_a: assert property ( // see RL6
      s_cap_id |=> id_shift == ID_VALUE)
      else $error("identification value not captured");
   bypass_cap_a: assert property ( // see RL11
      s_cap_bypass |=> !bypass_cell)
      else $error("bypass cell not cleared on capture");
   reset_hold_a: assert property ( // see RL10
      rst_reg |=> chip_reset)
      else $error("chip not held in reset");
   reset_tristate_a: assert property ( // see RL12
      chip_reset && !extest |=> pin_oe == '0)
      else $error("pins driven during chip reset");
   reset_timeout_a: assert property ( // see RL23
      $fell(rst_reg) |=> chip_reset [*2])
      else $error("reset time-out cut short");
   cause_set_a: assert property ( // see RL16
      rst_reg |=> cause_flag)
      else $error("reset cause flag not set");
   timed_write_a: assert property ( // see RL14
      $changed(test_port_disable) |->
      $past(wr_ctl) && $past(tpd_arm) && $past(tpd_val) == $past(wd_tpd))
      else $error("disable bit changed without timed write");
endmodule : boundary_scan_test_access

//--- tb/test_ctrl_model.sv
`timescale 1ns/1ps
module test_ctrl_model (
   // Pacing clock
   input wire logic clk_sys,
   // Link lines driven by the controller
   output logic tck,
   output logic tdi,
   output logic tap_reset,
   output logic tap_capture_ir,
   output logic tap_shift_ir,
   output logic tap_update_ir,
   output logic tap_capture_dr,
   output logic tap_shift_dr,
   output logic tap_update_dr,
   // Link lines from the device
   input wire logic tdo,
   input wire logic tdo_oe
);
   logic last_tdo;
   logic line_tdo;
   // A released data line is not trusted to keep its old level
   assign line_tdo = tdo_oe ? tdo : ~last_tdo;
   initial begin
      {tck, tdi, tap_reset, tap_capture_ir, tap_shift_ir} = 5'h00;
      {tap_update_ir, tap_capture_dr, tap_shift_dr, tap_update_dr} = 4'h0;
      last_tdo = 1'b0;
   end
   always @(posedge clk_sys) begin
      if (tdo_oe === 1'b1) begin
         last_tdo <= tdo;
      end
   end
   // One test clock period; tck stands low between frames
   task automatic tick(output logic smp);
      repeat (4) @(posedge clk_sys);
      tck <= 1'b1;
      repeat (2) @(posedge clk_sys);
      smp = line_tdo;
      repeat (2) @(posedge clk_sys);
      tck <= 1'b0;
   endtask : tick
   task automatic scan(input logic ir, input logic [31:0] din,
         input int len, output logic [31:0] dout, output logic oe);
      logic s;
      dout = 32'h0;
      tap_capture_ir <= ir;
      tap_capture_dr <= ~ir;
      tick(s);
      tap_capture_ir <= 1'b0;
      tap_capture_dr <= 1'b0;
      tap_shift_ir <= ir;
      tap_shift_dr <= ~ir;
      for (int i = 0; i < len; i++) begin
         tdi <= din[i];
         tick(s);
         dout[i] = s;
         oe = tdo_oe;
      end
      tap_shift_ir <= 1'b0;
      tap_shift_dr <= 1'b0;
      tap_update_ir <= ir;
      tap_update_dr <= ~ir;
      tick(s);
      tap_update_ir <= 1'b0;
      tap_update_dr <= 1'b0;
      tdi <= ~tdi;
      repeat (4) @(posedge clk_sys);
   endtask : scan
   task automatic tap_rst;
      logic s;
      tap_reset <= 1'b1;
      tick(s);
      tap_reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : tap_rst
endmodule : test_ctrl_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; \
   if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench import bscan_pkg::*; ;
   localparam logic [31:0] ID_EXP = {4'h3, 16'hC0DE, 11'h155, 1'b1};
   typedef struct packed {
      logic [3:0] code;
      logic [31:0] din;
      logic [31:0] dout;
   } row_t;
   logic clk_sys = 1'b0;
   logic rst_n, awvalid, wvalid, bready, arvalid, rready, test_port_fuse;
   logic [7:0] awaddr, araddr, pin_in, pin_port_bit, pin_direction_bit;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic global_pullup_disable, awready, wready, bvalid, arready, rvalid;
   logic [1:0] twowire_sys_enable, twowire_buffer_enable, bresp, rresp;
   logic tdo, tdo_oe, chip_reset, tck, tdi, tap_reset;
   logic tap_capture_ir, tap_shift_ir, tap_update_ir;
   logic tap_capture_dr, tap_shift_dr, tap_update_dr;
   logic [7:0] pin_out, pin_oe, pin_pullup_enable, pin_input_register;
   int bad_count = 0;
   int check_count = 0;
   always #20 clk_sys = ~clk_sys;
   // Identification values are arbitrary
   boundary_scan_test_access #(
      .PIN_COUNT(8), .TW_COUNT(2), .ID_VERSION(4'h3), .ID_PART(16'hC0DE),
      .ID_MFR(11'h155), .RESET_TIMEOUT(40)
   ) dut_u (
      .clk_sys, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .tck, .tdi, .tdo,
      .tdo_oe, .tap_reset, .tap_capture_ir, .tap_shift_ir, .tap_update_ir,
      .tap_capture_dr, .tap_shift_dr, .tap_update_dr, .test_port_fuse,
      .pin_in, .pin_out, .pin_oe, .pin_pullup_enable, .twowire_buffer_enable,
      .pin_port_bit, .pin_direction_bit, .global_pullup_disable,
      .twowire_sys_enable, .pin_input_register, .chip_reset
   );
   test_ctrl_model ctrl_u (
      .clk_sys, .tck, .tdi, .tap_reset, .tap_capture_ir, .tap_shift_ir,
      .tap_update_ir, .tap_capture_dr, .tap_shift_dr, .tap_update_dr,
      .tdo, .tdo_oe
   );
   function automatic logic [25:0] bvec(input logic [7:0] pu,
         input logic [7:0] oc, input logic [7:0] dat, input logic [1:0] tw);
      logic [25:0] v;
      v = {tw, 24'h0};
      for (int i = 0; i < 8; i++) begin
         v[3*i] = pu[i];
         v[3*i+1] = oc[i];
         v[3*i+2] = dat[i];
      end
      return v;
   endfunction : bvec
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
         output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      `CHK({r, d}, {RESP_OKAY, 24'h0, e})
   endtask : rchk
   // Timed pair, closer than the commit window
   task automatic wr2(input logic [7:0] d);
      logic [1:0] r;
      axi_wr(OFF_SYSCTRL, d, r);
      axi_wr(OFF_SYSCTRL, d, r);
   endtask : wr2
   initial begin
      #(1_000_000);
      bad_count++;
      final_report();
   end
   initial begin
      row_t rows [6];
      logic [31:0] sd, rd;
      logic [1:0] rs;
      logic oe;
      int n;
      rows = '{{4'h1, 32'h0, ID_EXP}, {4'hF, 32'h5, 32'hA},
         {4'h3, 32'h5, 32'hA}, {4'h7, 32'h9, 32'h12},
         {4'hA, 32'h5, 32'hA}, {4'hE, 32'h3, 32'h6}};
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      test_port_fuse = 1'b1;
      global_pullup_disable = 1'b0;
      pin_in = 8'h3C;
      pin_port_bit = 8'hA5;
      pin_direction_bit = 8'h0F;
      twowire_sys_enable = 2'b10;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[k]) begin
         ctrl_u.scan(1'b1, {28'h0, rows[k].code}, 4, sd, oe);
         `CHK(sd[3:0], IR_CAPTURE)
         `CHK(oe, 1'b1)
         rchk(OFF_STATUS, {4'h2, rows[k].code});
         ctrl_u.scan(1'b0, rows[k].din, 32, sd, oe);
         `CHK(sd, rows[k].dout)
      end
      ctrl_u.tap_rst();
      rchk(OFF_STATUS, 8'h21);
      ctrl_u.scan(1'b1, {28'h0, OP_BYPASS}, 4, sd, oe);
      // Second reset in mid-run must bring back the power-up instruction
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      rchk(OFF_SYSCTRL, 8'h00);
      rchk(OFF_CAUSE, 8'h00);
      rchk(OFF_STATUS, 8'h21);
      ctrl_u.scan(1'b0, 32'h0, 32, sd, oe);
      `CHK(sd, ID_EXP)
      `CHK({pin_oe, pin_out, pin_pullup_enable}, 24'h0FA5A0)
      `CHK(pin_input_register, 8'h3C)
      // System side values must reach the pins outside EXTEST
      global_pullup_disable <= 1'b1;
      twowire_sys_enable <= 2'b01;
      pin_direction_bit <= 8'hF0;
      repeat (2) @(posedge clk_sys);
      `CHK({pin_oe, pin_pullup_enable, twowire_buffer_enable}, 18'h3C001)
      global_pullup_disable <= 1'b0;
      twowire_sys_enable <= 2'b10;
      pin_direction_bit <= 8'h0F;
      repeat (2) @(posedge clk_sys);
      ctrl_u.scan(1'b1, {28'h0, OP_SAMPLE}, 4, sd, oe);
      ctrl_u.scan(1'b0, {6'h0, bvec(8'h33, 8'h55, 8'h99, 2'b00)}, 26, sd,
         oe);
      `CHK(sd[25:0], bvec(8'hA0, 8'h0F, 8'h3C, 2'b10))
      `CHK({pin_oe, pin_out}, 16'h0FA5)
      ctrl_u.scan(1'b1, {28'h0, OP_EXTEST}, 4, sd, oe);
      `CHK({pin_oe, pin_out, pin_pullup_enable}, 24'h559933)
      pin_in <= 8'hC3;
      ctrl_u.scan(1'b0, {6'h0, bvec(8'hCC, 8'h00, 8'h5A, 2'b01)}, 26, sd,
         oe);
      `CHK(sd[25:0], bvec(8'hA0, 8'h0F, 8'hC3, 2'b10))
      `CHK({pin_oe, pin_out, pin_pullup_enable}, 24'h005ACC)
      `CHK(twowire_buffer_enable, 2'b01)
      ctrl_u.scan(1'b1, {28'h0, OP_CHIP_RESET}, 4, sd, oe);
      ctrl_u.scan(1'b0, 32'h1, 1, sd, oe);
      `CHK({chip_reset, pin_oe}, 9'h100)
      rchk(OFF_STATUS, 8'h3C);
      rchk(OFF_CAUSE, 8'h10);
      ctrl_u.scan(1'b0, 32'h0, 1, sd, oe);
      `CHK(chip_reset, 1'b1)
      n = 0;
      while (chip_reset !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK(n > 20 && n < 40, 1'b1)
      axi_wr(OFF_CAUSE, 8'h10, rs);
      rchk(OFF_CAUSE, 8'h10);
      axi_wr(OFF_CAUSE, 8'h00, rs);
      rchk(OFF_CAUSE, 8'h00);
      axi_wr(OFF_SYSCTRL, 8'h85, rs);
      repeat (8) @(posedge clk_sys);
      rchk(OFF_SYSCTRL, 8'h05);
      wr2(8'h80);
      rchk(OFF_SYSCTRL, 8'h80);
      ctrl_u.scan(1'b1, {28'h0, OP_BYPASS}, 4, sd, oe);
      `CHK(oe, 1'b0)
      rchk(OFF_STATUS, 8'h01);
      wr2(8'h00);
      rchk(OFF_STATUS, 8'h21);
      axi_wr(OFF_SYSCTRL, 8'h00, rs);
      axi_wr(OFF_SYSCTRL, 8'h80, rs);
      rchk(OFF_SYSCTRL, 8'h00);
      axi_wr(8'h10, 8'h80, rs);
      `CHK(rs, RESP_SLVERR)
      axi_rd(8'h0C, rd, rs);
      `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
      // A pair without the low byte strobe must not move the bit
      wstrb <= 4'hE;
      wr2(8'h80);
      wstrb <= 4'hF;
      rchk(OFF_SYSCTRL, 8'h00);
      test_port_fuse <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rchk(OFF_STATUS, 8'h01);
      test_port_fuse <= 1'b1;
      wr2(8'h80);
      rchk(OFF_STATUS, 8'h01);
      final_report();
   end
endmodule : testbench
